// ===== hdl/dual_adc_fmt_pkg.sv
`default_nettype none
package dual_adc_fmt_pkg;
   localparam int DIFF_W = 24;
   localparam int DIFF16_W = 16;
   localparam int CM_W = 8;
   localparam int GAIN_W = 16;
   localparam int WORD_W = 32;
   localparam int RAW_W = 26;
   localparam int GAIN_SHIFT = 15;
   localparam logic [DIFF_W-1:0] DIFF_MAX = 24'h7FFFFF;
   localparam logic [DIFF_W-1:0] DIFF_MIN = 24'h800000;
   localparam logic [DIFF_W-1:0] OFFSET_RST = 24'h000000;
   localparam logic [GAIN_W-1:0] GAIN_RST = 16'h8000;
   localparam logic [CM_W-1:0] CM_MAX = 8'hFF;
   localparam logic [CM_W-1:0] CM_MIN = 8'h00;
   localparam int CONV_TIME_NS = 300;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   typedef enum logic [2:0] {
      FMT_DIFF24 = 3'h0,
      FMT_DIFF16_CM = 3'h1,
      FMT_DIFF24_CM = 3'h2,
      FMT_AVG = 3'h3,
      FMT_PATTERN = 3'h4
   } fmt_t;
endpackage
`default_nettype wire

// ===== hdl/dual_adc_sample_formatter.sv
`default_nettype none
module dual_adc_sample_formatter #(
   parameter int CONV_CNT = dual_adc_fmt_pkg::CONV_CYCLES
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Conversion start from the host pin
   input wire logic i_convert_start_input,
   input wire logic i_power_down,
   // Raw converter codes, signed, wide enough to show overrange
   input wire logic signed [dual_adc_fmt_pkg::RAW_W-1:0] i_raw_diff0,
   input wire logic signed [dual_adc_fmt_pkg::RAW_W-1:0] i_raw_diff1,
   input wire logic signed [dual_adc_fmt_pkg::RAW_W-1:0] i_raw_cm0,
   input wire logic signed [dual_adc_fmt_pkg::RAW_W-1:0] i_raw_cm1,
   // Configuration
   input wire logic [2:0] i_output_format_select,
   input wire logic [dual_adc_fmt_pkg::DIFF_W-1:0] i_offset0,
   input wire logic [dual_adc_fmt_pkg::DIFF_W-1:0] i_offset1,
   input wire logic [dual_adc_fmt_pkg::GAIN_W-1:0] i_channel_scale_factor0,
   input wire logic [dual_adc_fmt_pkg::GAIN_W-1:0] i_channel_scale_factor1,
   // Status and output register feeding the serial result lanes
   output logic o_busy,
   output logic o_result_valid,
   output logic [dual_adc_fmt_pkg::WORD_W-1:0] o_serial_result_lanes0,
   output logic [dual_adc_fmt_pkg::WORD_W-1:0] o_serial_result_lanes1
);
   import dual_adc_fmt_pkg::*;

   typedef enum {ST_ACQ, ST_CONV} state_t;

   localparam logic signed [RAW_W-1:0] RAW_MAX = RAW_W'(signed'(DIFF_MAX));
   localparam logic signed [RAW_W-1:0] RAW_MIN = RAW_W'(signed'(DIFF_MIN));
   localparam int PROD_W = RAW_W + GAIN_W + 2;

   // Clamp a raw code to the 24-bit full-scale range
   function automatic logic [DIFF_W-1:0] sat_raw(input logic signed [RAW_W-1:0] v);
      if (v > RAW_MAX)
         sat_raw = DIFF_MAX;
      else if (v < RAW_MIN)
         sat_raw = DIFF_MIN;
      else
         sat_raw = v[DIFF_W-1:0];
   endfunction

   // Offset, gain, then saturate to 24 bits
   function automatic logic [DIFF_W-1:0] scale(input logic [DIFF_W-1:0] d,
                                               input logic [DIFF_W-1:0] off,
                                               input logic [GAIN_W-1:0] g);
      logic signed [PROD_W-1:0] sum;
      logic signed [PROD_W-1:0] prod;
      sum = PROD_W'(signed'(d)) + PROD_W'(signed'(off));
      prod = (sum * signed'({2'b00, g})) >>> GAIN_SHIFT;
      if (prod > PROD_W'(signed'(DIFF_MAX)))
         scale = DIFF_MAX;
      else if (prod < PROD_W'(signed'(DIFF_MIN)))
         scale = DIFF_MIN;
      else
         scale = prod[DIFF_W-1:0];
   endfunction

   // Common-mode code, clamped to 0..255, never scaled
   function automatic logic [CM_W-1:0] cm_code(input logic signed [RAW_W-1:0] v);
      if (v < 0)
         cm_code = CM_MIN;
      else if (v > RAW_W'(CM_MAX))
         cm_code = CM_MAX;
      else
         cm_code = v[CM_W-1:0];
   endfunction

   // Pack one channel word per format
   function automatic logic [WORD_W-1:0] pack(input logic [DIFF_W-1:0] d,
                                              input logic [CM_W-1:0] cm,
                                              input logic [2:0] f);
      case (f)
         FMT_DIFF16_CM: pack = {d[DIFF_W-1 -: DIFF16_W], cm, CM_MIN};
         FMT_DIFF24_CM: pack = {d, cm};
         default: pack = {d, CM_MIN};
      endcase
   endfunction

   // Start pin synchroniser: a change counts once stages two and three agree
   logic [2:0] cnv_sync_r;
   logic [2:0] cnv_sync_nxt;
   logic cnv_level_r;
   logic cnv_level_nxt;
   state_t state_r;
   state_t state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic busy_r;
   logic busy_nxt;
   logic valid_r;
   logic valid_nxt;
   logic [RAW_W-1:0] hold_d0_r, hold_d1_r, hold_c0_r, hold_c1_r;
   logic [RAW_W-1:0] hold_d0_nxt, hold_d1_nxt, hold_c0_nxt, hold_c1_nxt;
   logic [WORD_W-1:0] out0_r;
   logic [WORD_W-1:0] out0_nxt;
   logic [WORD_W-1:0] out1_r;
   logic [WORD_W-1:0] out1_nxt;
   logic start_edge;

   always_comb begin
      cnv_sync_nxt = {cnv_sync_r[1:0], i_convert_start_input};
      cnv_level_nxt = cnv_level_r;
      if (cnv_sync_r[2] == cnv_sync_r[1])
         cnv_level_nxt = cnv_sync_r[2];
      start_edge = cnv_level_nxt && !cnv_level_r;
   end

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      busy_nxt = busy_r;
      valid_nxt = 1'b0;
      hold_d0_nxt = hold_d0_r;
      hold_d1_nxt = hold_d1_r;
      hold_c0_nxt = hold_c0_r;
      hold_c1_nxt = hold_c1_r;
      out0_nxt = out0_r;
      out1_nxt = out1_r;
      case (state_r)
         ST_ACQ: begin
            // Power-down only blocks new starts; nothing stale survives, so
            // the first conversion after it is already good
            if (start_edge && !i_power_down) begin
               hold_d0_nxt = i_raw_diff0;
               hold_d1_nxt = i_raw_diff1;
               hold_c0_nxt = i_raw_cm0;
               hold_c1_nxt = i_raw_cm1;
               busy_nxt = 1'b1;
               cnt_nxt = CNT_W'(CONV_CNT - 1);
               state_nxt = ST_CONV;
            end
         end
         ST_CONV: begin
            if (cnt_r == '0) begin
               out0_nxt = pack(scale(sat_raw(hold_d0_r), i_offset0, i_channel_scale_factor0),
                               cm_code(hold_c0_r), i_output_format_select);
               out1_nxt = pack(scale(sat_raw(hold_d1_r), i_offset1, i_channel_scale_factor1),
                               cm_code(hold_c1_r), i_output_format_select);
               busy_nxt = 1'b0;
               valid_nxt = 1'b1;
               state_nxt = ST_ACQ;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         default: state_nxt = ST_ACQ;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnv_sync_r <= '0;
         cnv_level_r <= 1'b0;
         state_r <= ST_ACQ;
         cnt_r <= '0;
         busy_r <= 1'b0;
         valid_r <= 1'b0;
         hold_d0_r <= '0;
         hold_d1_r <= '0;
         hold_c0_r <= '0;
         hold_c1_r <= '0;
         out0_r <= '0;
         out1_r <= '0;
      end else begin
         cnv_sync_r <= cnv_sync_nxt;
         cnv_level_r <= cnv_level_nxt;
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         busy_r <= busy_nxt;
         valid_r <= valid_nxt;
         hold_d0_r <= hold_d0_nxt;
         hold_d1_r <= hold_d1_nxt;
         hold_c0_r <= hold_c0_nxt;
         hold_c1_r <= hold_c1_nxt;
         out0_r <= out0_nxt;
         out1_r <= out1_nxt;
      end
   end

   assign o_busy = busy_r;
   assign o_result_valid = valid_r;
   assign o_serial_result_lanes0 = out0_r;
   assign o_serial_result_lanes1 = out1_r;
endmodule
`default_nettype wire

// ===== testbench/conv_host_model.sv
`default_nettype none
module conv_host_model (
   input wire logic i_mclk,
   input wire logic i_go,
   output logic o_start
);
   timeunit 1ns;
   timeprecision 1ps;
   int hold = 0;
   // Pin stays up a few cycles then drops, so the next request sees a fresh rising edge
   always @(posedge i_mclk) hold <= i_go ? 5 : (hold > 0 ? hold - 1 : 0);
   assign o_start = hold != 0;
endmodule
`default_nettype wire

// ===== testbench/dual_adc_fmt_monitor.sv
`default_nettype none
module dual_adc_fmt_monitor #(
   parameter int CONV_CNT = 30
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_convert_start_input,
   input wire logic i_power_down,
   input wire logic [2:0] i_output_format_select,
   input wire logic o_busy,
   input wire logic o_result_valid,
   input wire logic [31:0] o_serial_result_lanes0,
   input wire logic [31:0] o_serial_result_lanes1
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   chk_busy_done: assert property (
      $rose(o_busy) |-> ##CONV_CNT (!o_busy && o_result_valid)) else $error("busy end late");
   chk_busy_span: assert property (
      $fell(o_busy) |-> $past(o_busy, CONV_CNT) && !$past(o_busy, CONV_CNT + 1))
      else $error("busy length wrong");
   chk_valid_pulse: assert property (
      o_result_valid |=> !o_result_valid) else $error("valid longer than one cycle");
   chk_valid_idle: assert property (
      o_result_valid |-> !o_busy) else $error("valid while busy");
   chk_start_busy: assert property (
      $rose(i_convert_start_input) && !o_busy && !i_power_down |-> ##[2:4] $rose(o_busy))
      else $error("start edge ignored");
   chk_pd_block: assert property (
      $rose(o_busy) |-> !$past(i_power_down)) else $error("start taken in power-down");
   chk_words_hold: assert property (
      !o_result_valid |-> $stable(o_serial_result_lanes0) && $stable(o_serial_result_lanes1))
      else $error("words moved without valid");
   chk_fmt_pad: assert property (
      o_result_valid && i_output_format_select != 3'h2 |->
      o_serial_result_lanes0[7:0] == 8'h00 && o_serial_result_lanes1[7:0] == 8'h00)
      else $error("pad byte not zero");
endmodule
`default_nettype wire

// ===== testbench/dual_adc_sample_formatter_tb.sv
`default_nettype none
module dual_adc_sample_formatter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dual_adc_fmt_pkg::*;
   localparam int CONV_CNT = 3;
   logic clk = 0, rst_n = 0, go = 0, pd = 0, start, busy, valid;
   logic signed [25:0] rd0 = 0, rd1 = 0, rc0 = 0, rc1 = 0;
   logic [2:0] fmt = 0;
   logic [23:0] of0 = 0, of1 = 0;
   logic [15:0] g0 = 16'h8000, g1 = 16'h8000;
   logic [31:0] w0, w1;
   int errors = 0, compares = 0, seen;
   int cr[6] = '{9000000, -9000000, 8388607, -8388608, -1, 100};
   logic [23:0] co[6] = '{24'h0, 24'h0, 24'h1, 24'hFFFFFF, 24'h0, 24'h0};
   dual_adc_sample_formatter #(.CONV_CNT(CONV_CNT)) dual_adc_sample_formatter_inst (
      .i_mclk(clk), .i_rst_n(rst_n), .i_convert_start_input(start), .i_power_down(pd),
      .i_raw_diff0(rd0), .i_raw_diff1(rd1), .i_raw_cm0(rc0), .i_raw_cm1(rc1),
      .i_output_format_select(fmt), .i_offset0(of0), .i_offset1(of1),
      .i_channel_scale_factor0(g0), .i_channel_scale_factor1(g1), .o_busy(busy),
      .o_result_valid(valid), .o_serial_result_lanes0(w0), .o_serial_result_lanes1(w1));
   conv_host_model conv_host_model_inst (.i_mclk(clk), .i_go(go), .o_start(start));
   initial begin
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] exp_word(logic signed [25:0] r, logic signed [25:0] c,
         logic [23:0] o, logic [15:0] g, logic [2:0] f);
      longint s;
      logic [7:0] m;
      s = r;
      s = s > 8388607 ? 8388607 : (s < -8388608 ? -8388608 : s);
      s = ((s + longint'($signed(o))) * longint'(g)) >>> 15;
      s = s > 8388607 ? 8388607 : (s < -8388608 ? -8388608 : s);
      m = c < 0 ? 8'h00 : (c > 255 ? 8'hFF : c[7:0]);
      case (f)
         3'h1: return {s[23:8], m, 8'h00};
         3'h2: return {s[23:0], m};
         default: return {s[23:0], 8'h00};
      endcase
   endfunction
   task check(string n, logic [31:0] s, logic [31:0] e);
      compares++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task report_and_stop;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task conv;
      int n;
      n = 0;
      go = 1;
      @(posedge clk);
      #1 go = 0;
      while (valid !== 1'b1) begin
         @(posedge clk);
         #1 n++;
         if (n > 50) begin
            errors++;
            report_and_stop();
         end
      end
      check("lane0", w0, exp_word(rd0, rc0, of0, g0, fmt));
      check("lane1", w1, exp_word(rd1, rc1, of1, g1, fmt));
      // Pin must sit low a while before the next rising edge counts
      repeat (3) @(posedge clk);
      #1;
   endtask
   initial begin
      void'($urandom(32'hF10A));
      repeat (3) @(posedge clk);
      #1 rst_n = 1;
      for (int i = 0; i < 6; i++) begin
         rd0 = 26'(cr[i]);
         rd1 = 26'(-cr[i]);
         of0 = co[i];
         g0 = i == 5 ? 16'hFFFF : 16'h8000;
         rc0 = 26'(i * 60 - 40);
         fmt = 3'(i % 3);
         conv();
      end
      pd = 1;
      go = 1;
      seen = 0;
      @(posedge clk);
      #1 go = 0;
      repeat (20) begin
         @(posedge clk);
         #1 seen = seen | busy;
      end
      check("busy in power-down", 32'(seen), 32'h0);
      pd = 0;
      conv();
      for (int i = 0; i < 40; i++) begin
         rd0 = 26'(int'($urandom % 20000000) - 10000000);
         rd1 = 26'(int'($urandom % 20000000) - 10000000);
         rc0 = 26'(int'($urandom_range(0, 300)) - 20);
         rc1 = 26'(int'($urandom_range(0, 300)) - 20);
         of0 = 24'(int'($urandom % 200000) - 100000);
         of1 = 24'($urandom);
         g0 = 16'($urandom);
         g1 = 16'($urandom);
         fmt = 3'($urandom_range(0, 4));
         conv();
      end
      report_and_stop();
   end
endmodule
bind dual_adc_sample_formatter dual_adc_fmt_monitor #(.CONV_CNT(CONV_CNT)) mon_inst (
   .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_convert_start_input(i_convert_start_input),
   .i_power_down(i_power_down), .i_output_format_select(i_output_format_select),
   .o_busy(o_busy), .o_result_valid(o_result_valid),
   .o_serial_result_lanes0(o_serial_result_lanes0),
   .o_serial_result_lanes1(o_serial_result_lanes1));
`default_nettype wire
